/* shared/tc_status_defines.svh */
// Offsets, field positions, reset values and codes of the status bank
`ifndef TC_STATUS_DEFINES_SVH
`define TC_STATUS_DEFINES_SVH

`define CH_STATUS_OFFS     8'h00
`define ERR_STATUS_OFFS    8'h04
`define ERR_ENABLE_OFFS    8'h08
`define ERR_CLEAR_OFFS     8'h0C
`define ERR_DETAIL_OFFS    8'h10

`define ST_PROG_BUSY_BIT   0
`define ST_SRC_ACTIVE_BIT  1
`define ST_WR_PEND_BIT     2
`define ST_OCC_LSB         4
`define ST_ONE_BIT         8
`define ST_START_PTR_LSB   11

`define ERR_BUS_FAULT_BIT  0
`define ERR_REQ_CHECK_BIT  2
`define ERR_ADDR_BIT       3
`define ERR_IMPL_MASK      4'hD
`define ERR_RESET          4'h0
`define ERR_EN_RESET       4'h0

`define DET_TCC_LSB        8
`define DET_TCINTEN_BIT    16
`define DET_TCCHEN_BIT     17

`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`define DEST_DEPTH_DEFAULT 4
`define CONST_ALIGN_BITS   5
`define PEND_CNT_W         4

`endif

/* shared/tc_status_pkg.sv */
// Types shared by the status and error register bank
package tc_status_pkg;

    // Transfer request as handed in by the channel controller
    typedef struct packed {
        logic        src_const;
        logic        dst_const;
        logic [31:0] src_addr;
        logic [31:0] dst_addr;
        logic [15:0] first_dim_count;
        logic [15:0] second_dim_count;
    } tr_req_t;

    // Status returned by the read or write side of the bus
    typedef struct packed {
        logic [3:0] stat;
        logic [5:0] tcc;
        logic       tcinten;
        logic       tcchen;
    } xfer_status_t;

    typedef enum logic {
        PROG_IDLE,
        PROG_HELD
    } prog_state_t;

endpackage

/* design/dest_queue_tracker.sv */
// Occupancy and head pointer of the destination request queue
`timescale 1ns/1ps
`default_nettype none

module dest_queue_tracker
    import tc_status_pkg::*;
#(
    parameter int DEPTH = 4
) (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       push,
    input  wire logic       pop,
    output logic      [2:0] occupancy,
    output logic      [1:0] start_ptr,
    output logic            full,
    output logic            empty
);

    generate
        if (!(DEPTH == 2 || DEPTH == 4)) begin : g_bad_depth
            $error("dest_queue_tracker: DEPTH must be 2 or 4");
        end
    endgenerate

    localparam logic [2:0] DEPTH_C = 3'(DEPTH);
    localparam logic [1:0] LAST_C  = 2'(DEPTH - 1);

    logic [2:0] count_q;
    logic [2:0] count_d;
    logic [1:0] ptr_q;
    logic [1:0] ptr_d;
    wire        do_push = push && (count_q != DEPTH_C);
    wire        do_pop  = pop && (count_q != 3'h0);

    assign count_d = count_q + 3'(do_push) - 3'(do_pop);
    assign ptr_d   = !do_pop ? ptr_q : (ptr_q == LAST_C) ? 2'h0 : ptr_q + 2'h1;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            count_q <= 3'h0;
            ptr_q   <= 2'h0;
        end else begin
            count_q <= count_d;
            ptr_q   <= ptr_d;
        end
    end

    assign occupancy = count_q;
    assign start_ptr = ptr_q;
    assign full      = (count_q == DEPTH_C);
    assign empty     = (count_q == 3'h0);

    a_occ_bound: assert property (@(posedge core_clk) disable iff (!rst_n)
        count_q <= DEPTH_C)
        else $error("queue occupancy above depth");

endmodule // dest_queue_tracker

`default_nettype wire

/* design/transfer_ctrl_status_error_regs.sv */
// Status and error register bank of a transfer controller
//
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "tc_status_defines.svh"

module transfer_ctrl_status_error_regs
    import tc_status_pkg::*;
#(
    parameter int ADDR_W                 = 8,
    parameter int dest_queue_depth_param = `DEST_DEPTH_DEFAULT
) (
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    // AXI4-Lite register port
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              wvalid,
    output logic                   wready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    output logic                   bvalid,
    input  wire logic              bready,
    output logic      [1:0]        bresp,
    input  wire logic              arvalid,
    output logic                   arready,
    input  wire logic [ADDR_W-1:0] araddr,
    output logic                   rvalid,
    input  wire logic              rready,
    output logic      [31:0]       rdata,
    output logic      [1:0]        rresp,
    // Channel controller side
    input  wire logic              tr_valid,
    input  wire tr_req_t           tr_req,
    output logic                   program_set_busy,
    // Data mover side
    output logic                   dest_admit,
    output tr_req_t                dest_tr,
    input  wire logic              head_complete,
    input  wire logic              source_engine_active,
    input  wire logic              wr_cmd_issued,
    input  wire logic              wr_resp_recv,
    input  wire logic              rd_status_valid,
    input  wire xfer_status_t      rd_status,
    input  wire logic              wr_status_valid,
    input  wire xfer_status_t      wr_status,
    output logic                   error_irq
);

    generate
        if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
            $error("ADDR_W must lie between 8 and 32");
        end
    endgenerate

    // ---------------- Program set and destination queue ----------------
    prog_state_t prog_q;
    prog_state_t prog_d;
    tr_req_t     hold_q;
    logic [2:0]  dest_queue_occupancy;
    logic [1:0]  q_start_ptr;
    logic        q_full;
    logic        q_empty;

    localparam logic [`CONST_ALIGN_BITS-1:0] ALIGN_ZERO = '0;

    wire src_misalign = tr_req.src_const &&
        (tr_req.src_addr[`CONST_ALIGN_BITS-1:0] != ALIGN_ZERO);
    wire dst_misalign = tr_req.dst_const &&
        (tr_req.dst_addr[`CONST_ALIGN_BITS-1:0] != ALIGN_ZERO);
    wire zero_count   = (tr_req.first_dim_count == 16'h0000) ||
                        (tr_req.second_dim_count == 16'h0000);
    // Writes while busy are ignored; the controller must wait
    wire tr_take      = tr_valid && (prog_q == PROG_IDLE);
    wire req_bad      = src_misalign || dst_misalign || zero_count;
    wire req_err_ev   = tr_take && req_bad;

    wire can_admit    = q_empty || (!q_full && !source_engine_active);
    assign dest_admit = (prog_q == PROG_HELD) && can_admit;

    always_comb begin
        prog_d = prog_q;
        unique case (prog_q)
            PROG_IDLE: begin
                if (tr_take && !req_bad) begin
                    prog_d = PROG_HELD;
                end
            end
            PROG_HELD: begin
                if (can_admit) begin
                    prog_d = PROG_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            prog_q <= PROG_IDLE;
            hold_q <= '0;
        end else begin
            prog_q <= prog_d;
            if (tr_take && !req_bad) begin
                hold_q <= tr_req;
            end
        end
    end

    assign dest_tr          = hold_q;
    // busy while a request is held
    assign program_set_busy = (prog_q == PROG_HELD);

    dest_queue_tracker #(
        .DEPTH (dest_queue_depth_param)
    ) u_dest_queue (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .push      (dest_admit),
        .pop       (head_complete),
        .occupancy (dest_queue_occupancy),
        .start_ptr (q_start_ptr),
        .full      (q_full),
        .empty     (q_empty)
    );

    // ---------------- Outstanding write responses ----------------
    logic [`PEND_CNT_W-1:0] pend_q;
    logic                   write_response_pending;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pend_q <= '0;
        end else begin
            pend_q <= pend_q + `PEND_CNT_W'(wr_cmd_issued)
                             - `PEND_CNT_W'(wr_resp_recv);
        end
    end

    assign write_response_pending = (pend_q != '0);

    // ---------------- AXI4-Lite slave ----------------
    logic              aw_held_q;
    logic              w_held_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0]       w_data_q;
    logic              w_lane0_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              rvalid_q;
    logic [31:0]       rdata_q;
    logic [1:0]        rresp_q;
    logic [31:0]       rd_word;

    function automatic logic is_reg(input logic [ADDR_W-1:0] a,
                                    input logic [7:0] offs);
        return a == ADDR_W'(offs);
    endfunction

    assign awready = !aw_held_q && !bvalid_q;
    assign wready  = !w_held_q && !bvalid_q;
    assign arready = !rvalid_q;
    wire aw_take   = awvalid && awready;
    wire w_take    = wvalid && wready;
    wire ar_take   = arvalid && arready;
    // Address and data may arrive in either order
    wire wr_go     = aw_held_q && w_held_q;

    wire wr_stat   = is_reg(aw_addr_q, `CH_STATUS_OFFS);
    wire wr_err    = is_reg(aw_addr_q, `ERR_STATUS_OFFS);
    wire wr_en     = is_reg(aw_addr_q, `ERR_ENABLE_OFFS);
    wire wr_clr    = is_reg(aw_addr_q, `ERR_CLEAR_OFFS);
    wire wr_det    = is_reg(aw_addr_q, `ERR_DETAIL_OFFS);
    wire wr_hit    = wr_stat || wr_err || wr_en || wr_clr || wr_det;
    wire rd_stat   = is_reg(araddr, `CH_STATUS_OFFS);
    wire rd_err    = is_reg(araddr, `ERR_STATUS_OFFS);
    wire rd_en     = is_reg(araddr, `ERR_ENABLE_OFFS);
    wire rd_clr    = is_reg(araddr, `ERR_CLEAR_OFFS);
    wire rd_det    = is_reg(araddr, `ERR_DETAIL_OFFS);
    wire rd_hit    = rd_stat || rd_err || rd_en || rd_clr || rd_det;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            aw_addr_q <= '0;
            w_data_q  <= 32'h0000_0000;
            w_lane0_q <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= awaddr;
            end else if (wr_go) begin
                aw_held_q <= 1'b0;
            end
            if (w_take) begin
                w_held_q  <= 1'b1;
                w_data_q  <= wdata;
                w_lane0_q <= wstrb[0];
            end else if (wr_go) begin
                w_held_q <= 1'b0;
            end
            if (wr_go) begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    assign bvalid = bvalid_q;
    assign bresp  = bresp_q;

    // ---------------- Error status, enable, detail ----------------
    logic [3:0]   err_q;
    logic [3:0]   err_d;
    logic [3:0]   en_q;
    xfer_status_t det_q;
    logic [3:0]   clr_vec;
    logic [3:0]   set_vec;

    wire addr_err_ev = (wr_go && !wr_hit) || (ar_take && !rd_hit);
    // write status wins when both report
    wire wr_bad      = wr_status_valid && (wr_status.stat != 4'h0);
    wire rd_bad      = rd_status_valid && (rd_status.stat != 4'h0);
    wire bus_ev      = wr_bad || rd_bad;
    wire xfer_status_t bus_info = wr_bad ? wr_status : rd_status;

    // Only the low byte lane holds the writable enable and clear bits
    wire wr_lane0 = wr_go && w_lane0_q;
    assign clr_vec = (wr_lane0 && wr_clr) ?
                     (w_data_q[3:0] & `ERR_IMPL_MASK) : 4'h0;
    assign set_vec = {addr_err_ev, req_err_ev, 1'b0, bus_ev};
    // a new event wins over a clear
    assign err_d   = (err_q & ~clr_vec) | set_vec;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            err_q <= `ERR_RESET;
            en_q  <= `ERR_EN_RESET;
            det_q <= '0;
        end else begin
            err_q <= err_d;
            if (wr_lane0 && wr_en) begin
                en_q <= w_data_q[3:0];
            end
            if (bus_ev) begin
                det_q <= bus_info;
            end else if (clr_vec[`ERR_BUS_FAULT_BIT]) begin
                det_q <= '0;
            end
        end
    end

    assign error_irq = |(err_q & en_q & `ERR_IMPL_MASK);

    // ---------------- Read data ----------------
    logic [31:0] stat_word;
    logic [31:0] det_word;

    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[`ST_PROG_BUSY_BIT]  = program_set_busy;
        stat_word[`ST_SRC_ACTIVE_BIT] = source_engine_active;
        stat_word[`ST_WR_PEND_BIT]    = write_response_pending;
        stat_word[`ST_OCC_LSB +: 3]   = dest_queue_occupancy;
        stat_word[`ST_ONE_BIT]        = 1'b1;
        stat_word[`ST_START_PTR_LSB +: 2] = q_start_ptr;
        det_word = 32'h0000_0000;
        det_word[3:0]                 = det_q.stat;
        det_word[`DET_TCC_LSB +: 6]   = det_q.tcc;
        det_word[`DET_TCINTEN_BIT]    = det_q.tcinten;
        det_word[`DET_TCCHEN_BIT]     = det_q.tcchen;
    end

    assign rd_word = rd_stat ? stat_word :
                     rd_err  ? {28'h0, err_q} :
                     rd_en   ? {28'h0, en_q} :
                     rd_det  ? det_word : 32'h0000_0000;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= `RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_word;
            rresp_q  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign rvalid = rvalid_q;
    assign rdata  = rdata_q;
    assign rresp  = rresp_q;

    // ---------------- Checks ----------------
    sequence s_held_empty;
        (prog_q == PROG_HELD) && q_empty;
    endsequence
    sequence s_held_partial;
        (prog_q == PROG_HELD) && !q_empty && !q_full;
    endsequence
    sequence s_bad_read;
        ar_take && !rd_hit;
    endsequence

    a_admit_empty: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_held_empty |-> dest_admit ##1 !program_set_busy)
        else $error("held request not moved into empty queue");
    a_admit_partial: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_held_partial |-> (dest_admit == !source_engine_active))
        else $error("partial queue admission ignores source state");
    a_full_block: assert property (@(posedge core_clk) disable iff (!rst_n)
        q_full |-> !dest_admit)
        else $error("request admitted into full queue");
    a_wr_pending: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_cmd_issued && !wr_resp_recv |=> write_response_pending)
        else $error("pending write status not shown");
    a_src_shown: assert property (@(posedge core_clk) disable iff (!rst_n)
        ar_take && rd_stat |=> rdata[`ST_SRC_ACTIVE_BIT]
            == $past(source_engine_active))
        else $error("source active bit misreported");
    a_busy_prog: assert property (@(posedge core_clk) disable iff (!rst_n)
        tr_take && !req_bad |=> program_set_busy
            && dest_tr == $past(tr_req))
        else $error("program set not busy after accepted write");
    a_addr_error: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_bad_read |=> err_q[`ERR_ADDR_BIT]
            && rresp == `RESP_SLVERR)
        else $error("unmapped read not flagged");
    a_req_error: assert property (@(posedge core_clk) disable iff (!rst_n)
        req_err_ev |=> err_q[`ERR_REQ_CHECK_BIT] && !program_set_busy)
        else $error("bad request not flagged");
    a_bus_detail: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_bad |=> err_q[`ERR_BUS_FAULT_BIT]
            && det_q.stat == $past(wr_status.stat))
        else $error("bus fault or its detail not recorded");
    a_irq_raise: assert property (@(posedge core_clk) disable iff (!rst_n)
        bus_ev && en_q[`ERR_BUS_FAULT_BIT]
            && !(wr_lane0 && wr_en) |=> error_irq)
        else $error("enabled error did not raise interrupt");
    a_irq_fall: assert property (@(posedge core_clk) disable iff (!rst_n)
        clr_vec != 4'h0 && (err_q & ~clr_vec) == 4'h0 && set_vec == 4'h0
            |=> !error_irq)
        else $error("interrupt high with no enabled error");
    a_clear_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
        clr_vec != 4'h0 && !clr_vec[`ERR_BUS_FAULT_BIT] && !bus_ev
            |=> $stable(det_q))
        else $error("detail changed by non bus fault clear");

endmodule // transfer_ctrl_status_error_regs

`default_nettype wire

/* sim/chan_ctrl_model.sv */
// Behavioural channel controller that hands in transfer requests
`timescale 1ns/1ps
`default_nettype none

module chan_ctrl_model
    import tc_status_pkg::*;
(
    input  wire logic    core_clk,
    input  wire logic    rst_n,
    input  wire logic    send,
    input  wire tr_req_t new_req,
    input  wire logic    program_set_busy,
    output logic         tr_valid,
    output tr_req_t      tr_req
);
    logic    pend_q;
    tr_req_t hold_q;

    // Released lines show the inverse, so no stale request looks valid
    assign tr_req = tr_valid ? hold_q : ~hold_q;

    // offer only while program set idle
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pend_q   <= 1'b0;
            tr_valid <= 1'b0;
            hold_q   <= '0;
        end else begin
            tr_valid <= 1'b0;
            if (send) begin
                pend_q <= 1'b1;
                hold_q <= new_req;
            end else if (pend_q && !program_set_busy && !tr_valid) begin
                tr_valid <= 1'b1;
                pend_q   <= 1'b0;
            end
        end
    end
endmodule // chan_ctrl_model

`default_nettype wire

/* sim/tb_transfer_ctrl_status_error_regs.sv */
// Self-checking bench for the status and error register bank
`timescale 1ns/1ps
`default_nettype none
`include "tc_status_defines.svh"

module tb_transfer_ctrl_status_error_regs
    import tc_status_pkg::*;
();
    logic         core_clk = 1'b0, rst_n = 1'b0;
    logic         awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic [7:0]   awaddr = 8'h00, araddr = 8'h00;
    logic [31:0]  wdata = 32'h0;
    logic [3:0]   wstrb = 4'hF;
    logic         bready = 1'b1, rready = 1'b1;
    logic         send = 1'b0, head_complete = 1'b0;
    logic         source_engine_active = 1'b0;
    logic         wr_cmd_issued = 1'b0, wr_resp_recv = 1'b0;
    logic         rd_status_valid = 1'b0, wr_status_valid = 1'b0;
    xfer_status_t rd_status = '0, wr_status = '0;
    tr_req_t      new_req = '0;
    wire          awready, wready, bvalid, arready, rvalid;
    wire [1:0]    bresp, rresp;
    wire [31:0]   rdata;
    wire          tr_valid, program_set_busy, dest_admit, error_irq;
    tr_req_t      tr_req, dest_tr;
    int           err_total = 0, tests_run = 0, cycles = 0;

    transfer_ctrl_status_error_regs i_dut (.core_clk, .rst_n, .awvalid,
        .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid,
        .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
        .rdata, .rresp, .tr_valid, .tr_req, .program_set_busy, .dest_admit,
        .dest_tr, .head_complete, .source_engine_active, .wr_cmd_issued,
        .wr_resp_recv, .rd_status_valid, .rd_status, .wr_status_valid,
        .wr_status, .error_irq);

    chan_ctrl_model i_ctrl (.core_clk, .rst_n, .send, .new_req,
        .program_set_busy, .tr_valid, .tr_req);

    always #2.5 core_clk = ~core_clk;

    // Whole run needs a few hundred cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d,
                          output logic [1:0] r);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        forever begin
            @(posedge core_clk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid === 1'b1)
                break;
        end
        r = bresp;
    endtask

    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        araddr  <= a;
        arvalid <= 1'b1;
        forever begin
            @(posedge core_clk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid === 1'b1)
                break;
        end
        d = rdata;
        r = rresp;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        bus_rd(a, d, r);
        if (a == `CH_STATUS_OFFS)
            d = d & 32'hFFFF_E7FF;
        chk(d, exp);
        chk({30'h0, r}, {30'h0, `RESP_OKAY});
    endtask

    task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        bus_wr(a, d, r);
        chk({30'h0, r}, {30'h0, `RESP_OKAY});
    endtask

    function automatic logic [31:0] st(input int occ, input logic [3:0] f);
        return 32'h100 | (32'(occ) << `ST_OCC_LSB) | {28'h0, f};
    endfunction

    function automatic tr_req_t mk(input logic sc, input logic dc,
            input logic [31:0] sa, input logic [31:0] da,
            input logic [15:0] ca, input logic [15:0] cb);
        return '{sc, dc, sa, da, ca, cb};
    endfunction

    task automatic push_req(input tr_req_t q);
        send    <= 1'b1;
        new_req <= q;
        tick(1);
        send <= 1'b0;
        while (program_set_busy !== 1'b1)
            tick(1);
        chk(32'(dest_tr), 32'(q));
        chk(dest_tr.first_dim_count, q.first_dim_count);
    endtask

    task automatic until_idle();
        while (program_set_busy !== 1'b0)
            tick(1);
    endtask

    task automatic pulse_head();
        head_complete <= 1'b1;
        tick(1);
        head_complete <= 1'b0;
        tick(1);
    endtask

    task automatic t_reset();
        rd_chk(`CH_STATUS_OFFS, st(0, 4'h0));
        rd_chk(`ERR_STATUS_OFFS, 32'h0);
        rd_chk(`ERR_ENABLE_OFFS, 32'h0);
        chk(error_irq, 1'b0);
    endtask

    task automatic t_fill();
        logic [31:0] d;
        logic [1:0]  r;
        push_req(mk(0, 0, 32'h100, 32'h200, 16'h8, 16'h1));
        until_idle();
        rd_chk(`CH_STATUS_OFFS, st(1, 4'h0));
        source_engine_active <= 1'b1;
        tick(1);
        rd_chk(`CH_STATUS_OFFS, st(1, 4'h2));
        push_req(mk(1, 0, 32'h40, 32'h300, 16'h4, 16'h2));
        tick(6);
        chk(program_set_busy, 1'b1);
        rd_chk(`CH_STATUS_OFFS, st(1, 4'h3));
        source_engine_active <= 1'b0;
        until_idle();
        rd_chk(`CH_STATUS_OFFS, st(2, 4'h0));
        for (int i = 0; i < 2; i++) begin
            push_req(mk(0, 1, 32'h0, 32'h20, 16'h1, 16'h1));
            until_idle();
        end
        rd_chk(`CH_STATUS_OFFS, st(4, 4'h0));
        push_req(mk(0, 0, 32'h9, 32'h7, 16'hFFFF, 16'hFFFF));
        tick(6);
        rd_chk(`CH_STATUS_OFFS, st(4, 4'h1));
        pulse_head();
        until_idle();
        rd_chk(`CH_STATUS_OFFS, st(4, 4'h0));
        repeat (4) pulse_head();
        rd_chk(`CH_STATUS_OFFS, st(0, 4'h0));
        // Five pops in all leave the head pointer at entry 1
        bus_rd(`CH_STATUS_OFFS, d, r);
        chk({30'h0, d[12:11]}, 32'h1);
    endtask

    task automatic t_wr_pend();
        repeat (2) begin
            wr_cmd_issued <= 1'b1;
            tick(1);
            wr_cmd_issued <= 1'b0;
            tick(1);
        end
        for (int i = 0; i < 2; i++) begin
            rd_chk(`CH_STATUS_OFFS, st(0, 4'h4));
            wr_resp_recv <= 1'b1;
            tick(1);
            wr_resp_recv <= 1'b0;
            tick(1);
        end
        rd_chk(`CH_STATUS_OFFS, st(0, 4'h0));
    endtask

    task automatic t_bad_req();
        tr_req_t q;
        for (int i = 0; i < 4; i++) begin
            case (i)
                0: q = mk(0, 0, 32'h0, 32'h0, 16'h0, 16'h1);
                1: q = mk(0, 0, 32'h0, 32'h0, 16'h1, 16'h0);
                2: q = mk(1, 0, 32'h4, 32'h0, 16'h1, 16'h1);
                default: q = mk(0, 1, 32'h0, 32'h10, 16'h1, 16'h1);
            endcase
            send    <= 1'b1;
            new_req <= q;
            tick(1);
            send <= 1'b0;
            tick(6);
            chk(program_set_busy, 1'b0);
            rd_chk(`ERR_STATUS_OFFS, 32'h4);
            wr_ok(`ERR_CLEAR_OFFS, 32'h4);
            rd_chk(`ERR_STATUS_OFFS, 32'h0);
        end
    endtask

    task automatic t_errors();
        logic [31:0] d;
        logic [1:0]  r;
        bus_rd(8'h14, d, r);
        chk({30'h0, r}, {30'h0, `RESP_SLVERR});
        wr_ok(`CH_STATUS_OFFS, 32'hFFFF_FFFF);
        rd_chk(`ERR_STATUS_OFFS, 32'h8);
        chk(error_irq, 1'b0);
        wr_ok(`ERR_ENABLE_OFFS, 32'h8);
        rd_chk(`ERR_ENABLE_OFFS, 32'h8);
        chk(error_irq, 1'b1);
        rd_status       <= '{4'h5, 6'h11, 1'b0, 1'b1};
        wr_status       <= '{4'h9, 6'h2A, 1'b1, 1'b0};
        rd_status_valid <= 1'b1;
        wr_status_valid <= 1'b1;
        tick(1);
        rd_status_valid <= 1'b0;
        wr_status_valid <= 1'b0;
        tick(1);
        rd_chk(`ERR_STATUS_OFFS, 32'h9);
        rd_chk(`ERR_DETAIL_OFFS, 32'h0001_2A09);
        wr_ok(`ERR_CLEAR_OFFS, 32'h8);
        rd_chk(`ERR_DETAIL_OFFS, 32'h0001_2A09);
        chk(error_irq, 1'b0);
        wr_ok(`ERR_ENABLE_OFFS, 32'hD);
        chk(error_irq, 1'b1);
        // Read side fault alone, with its enable already set
        rd_status_valid <= 1'b1;
        tick(1);
        rd_status_valid <= 1'b0;
        tick(1);
        rd_chk(`ERR_DETAIL_OFFS, 32'h0002_1105);
        chk(error_irq, 1'b1);
        wr_ok(`ERR_CLEAR_OFFS, 32'h1);
        rd_chk(`ERR_STATUS_OFFS, 32'h0);
        rd_chk(`ERR_DETAIL_OFFS, 32'h0);
        chk(error_irq, 1'b0);
    endtask

    initial begin
        tick(8);
        rst_n <= 1'b1;
        tick(1);
        t_reset();
        t_fill();
        t_wr_pend();
        t_bad_req();
        t_errors();
        tick(2);
        end_of_test();
    end
endmodule // tb_transfer_ctrl_status_error_regs

`default_nettype wire
